// >>> hdl/epwc_spi_rx.sv
`timescale 1ns/1ns
`default_nettype none

module epwc_spi_rx (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic enable,
    // Link pins
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_sdi,
    input wire logic spi_dc,
    // Received byte
    output logic byte_valid,
    output epwc_pkg::epwc_byte_t byte_out
);

    logic [1:0] sclk_s;
    logic [1:0] csn_s;
    logic [1:0] sdi_s;
    logic [1:0] dc_s;
    logic sclk_d;
    logic [2:0] bit_cnt;
    logic [6:0] shift_reg;
    logic sclk_rise;

    ////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; stage 0 feeds stage 1 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_s <= 2'h0;
            csn_s <= 2'h3;
            sdi_s <= 2'h0;
            dc_s <= 2'h0;
            sclk_d <= 1'b0;
        end else begin
            sclk_s <= {sclk_s[0], spi_sclk};
            csn_s <= {csn_s[0], spi_csn};
            sdi_s <= {sdi_s[0], spi_sdi};
            dc_s <= {dc_s[0], spi_dc};
            sclk_d <= sclk_s[1];
        end
    end

    // Equal delay on clock and data keeps the sample point centred
    assign sclk_rise = sclk_s[1] & ~sclk_d;

    ////////////////////////////////////////////////////////////////
    // Shift MSB first; select high drops a partial byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 3'h0;
            shift_reg <= 7'h00;
            byte_valid <= 1'b0;
            byte_out <= '0;
        end else begin
            byte_valid <= 1'b0;
            if (csn_s[1] || !enable) begin
                bit_cnt <= 3'h0;
            end else if (sclk_rise) begin
                shift_reg <= {shift_reg[5:0], sdi_s[1]};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == epwc_pkg::LAST_BIT) begin
                    byte_valid <= 1'b1;
                    byte_out <= {dc_s[1], shift_reg, sdi_s[1]};
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> hdl/epwc_top.sv
// Notes on behaviour
// - Command 41h takes one byte; bit 0 picks readback, reset 0 = black-white RAM
// - Option bit 0 set to 1 sends RAM readback to the red image memory
// - Command 44h takes two bytes: 5-bit X start then X end
// - Command 45h takes four bytes: Y start low, bit 8, Y end low, bit 8
// - Command 4Eh takes one byte loading the 5-bit X address counter
// - Command 4Fh takes low byte then bit 8 of the Y address counter
`timescale 1ns/1ns
`default_nettype none

module epwc_top #(
    parameter int APB_AW = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link pins
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_sdi,
    input wire logic spi_dc,
    // Decoded settings
    output logic ram_read_sel,
    output epwc_pkg::epwc_win_t win,
    output epwc_pkg::epwc_ptr_t ram_address_pointer,
    output logic [7:0] analog_ctrl,
    output logic [7:0] digital_ctrl
);

    logic byte_valid;
    epwc_pkg::epwc_byte_t rx_byte;
    epwc_pkg::epwc_state_t state_reg;
    logic [7:0] cmd_reg;
    logic [1:0] idx_reg;
    logic link_en_reg;
    logic excess_reg;
    logic unknown_reg;
    logic read_sel_reg;
    epwc_pkg::epwc_win_t win_reg;
    epwc_pkg::epwc_ptr_t ptr_reg;
    logic [7:0] analog_reg;
    logic [7:0] digital_reg;
    logic cmd_take;
    logic par_take;
    logic excess_take;
    logic par_last;
    logic apb_setup;
    logic apb_write;
    logic [7:0] addr8;
    logic [31:0] rdata_next;

    ////////////////////////////////////////////////////////////////
    // Number of parameter bytes that follow a command code
    function automatic logic [2:0] param_count(input logic [7:0] c);
        case (c)
            epwc_pkg::CMD_READ_OPT,
            epwc_pkg::CMD_X_PTR,
            epwc_pkg::CMD_ANALOG,
            epwc_pkg::CMD_DIGITAL: param_count = epwc_pkg::NPAR_ONE;
            epwc_pkg::CMD_X_WIN,
            epwc_pkg::CMD_Y_PTR: param_count = epwc_pkg::NPAR_TWO;
            epwc_pkg::CMD_Y_WIN: param_count = epwc_pkg::NPAR_FOUR;
            default: param_count = epwc_pkg::NPAR_NONE;
        endcase
    endfunction

    // Register map decode
    function automatic logic addr_hit(input logic [7:0] a);
        case (a)
            epwc_pkg::REG_CTRL, epwc_pkg::REG_RAM_OPT,
            epwc_pkg::REG_X_WIN, epwc_pkg::REG_Y_WIN,
            epwc_pkg::REG_X_PTR, epwc_pkg::REG_Y_PTR,
            epwc_pkg::REG_ANALOG, epwc_pkg::REG_DIGITAL,
            epwc_pkg::REG_STATUS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // Byte receiver on the sampled link clock
    epwc_spi_rx u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .enable(link_en_reg),
        .spi_sclk(spi_sclk),
        .spi_csn(spi_csn),
        .spi_sdi(spi_sdi),
        .spi_dc(spi_dc),
        .byte_valid(byte_valid),
        .byte_out(rx_byte)
    );

    ////////////////////////////////////////////////////////////////
    // Byte classification by D/C level and decoder state
    assign cmd_take = byte_valid && !rx_byte.dc;
    assign par_take = byte_valid && rx_byte.dc && state_reg == epwc_pkg::EPWC_PARAM;
    assign excess_take = byte_valid && rx_byte.dc && state_reg == epwc_pkg::EPWC_IDLE;
    assign par_last = {1'b0, idx_reg} == param_count(cmd_reg) - 3'h1;

    // Command decoder: counts parameters, drops extras
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= epwc_pkg::EPWC_IDLE;
            cmd_reg <= 8'h00;
            idx_reg <= 2'h0;
        end else begin
            case (state_reg)
                epwc_pkg::EPWC_IDLE: begin
                    if (cmd_take && param_count(rx_byte.data) != epwc_pkg::NPAR_NONE) begin
                        state_reg <= epwc_pkg::EPWC_PARAM;
                    end
                end
                epwc_pkg::EPWC_PARAM: begin
                    if (par_take && par_last) begin
                        state_reg <= epwc_pkg::EPWC_IDLE;
                    end else if (cmd_take && param_count(rx_byte.data) == epwc_pkg::NPAR_NONE) begin
                        state_reg <= epwc_pkg::EPWC_IDLE;
                    end
                end
                default: state_reg <= epwc_pkg::EPWC_IDLE;
            endcase
            if (cmd_take) begin
                cmd_reg <= rx_byte.data;
                idx_reg <= 2'h0;
            end else if (par_take) begin
                idx_reg <= idx_reg + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Readback source option; a new command aborts an unfinished one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_sel_reg <= epwc_pkg::RST_READ_SEL;
        end else if (par_take && cmd_reg == epwc_pkg::CMD_READ_OPT) begin
            read_sel_reg <= rx_byte.data[0];
        end
    end

    // X and Y window positions; upper bits of the X bytes and the Y bit-8 bytes are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_reg <= {epwc_pkg::RST_X, epwc_pkg::RST_X, epwc_pkg::RST_Y, epwc_pkg::RST_Y};
        end else if (par_take && cmd_reg == epwc_pkg::CMD_X_WIN) begin
            if (idx_reg == 2'h0) begin
                win_reg.x_start <= rx_byte.data[epwc_pkg::XW-1:0];
            end else begin
                win_reg.x_end <= rx_byte.data[epwc_pkg::XW-1:0];
            end
        end else if (par_take && cmd_reg == epwc_pkg::CMD_Y_WIN) begin
            case (idx_reg)
                2'h0: win_reg.y_start[7:0] <= rx_byte.data;
                2'h1: win_reg.y_start[epwc_pkg::Y_HI] <= rx_byte.data[0];
                2'h2: win_reg.y_end[7:0] <= rx_byte.data;
                default: win_reg.y_end[epwc_pkg::Y_HI] <= rx_byte.data[0];
            endcase
        end
    end

    // RAM address counter preload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_reg <= {epwc_pkg::RST_X, epwc_pkg::RST_Y};
        end else if (par_take && cmd_reg == epwc_pkg::CMD_X_PTR) begin
            ptr_reg.x <= rx_byte.data[epwc_pkg::XW-1:0];
        end else if (par_take && cmd_reg == epwc_pkg::CMD_Y_PTR) begin
            if (idx_reg == 2'h0) begin
                ptr_reg.y[7:0] <= rx_byte.data;
            end else begin
                ptr_reg.y[epwc_pkg::Y_HI] <= rx_byte.data[0];
            end
        end
    end

    // Analog and digital block control bytes, kept as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_reg <= epwc_pkg::RST_BLOCK;
            digital_reg <= epwc_pkg::RST_BLOCK;
        end else if (par_take && cmd_reg == epwc_pkg::CMD_ANALOG) begin
            analog_reg <= rx_byte.data;
        end else if (par_take && cmd_reg == epwc_pkg::CMD_DIGITAL) begin
            digital_reg <= rx_byte.data;
        end
    end

    assign ram_read_sel = read_sel_reg;
    assign win = win_reg;
    assign ram_address_pointer = ptr_reg;
    assign analog_ctrl = analog_reg;
    assign digital_ctrl = digital_reg;

    ////////////////////////////////////////////////////////////////
    // APB: answer is prepared in setup, so access needs no wait state
    assign addr8 = 8'(paddr);
    assign apb_setup = psel && !penable && !pready;
    assign apb_write = psel && penable && pready && pwrite;

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (addr8)
            epwc_pkg::REG_CTRL: rdata_next[epwc_pkg::CTRL_EN_BIT] = link_en_reg;
            epwc_pkg::REG_RAM_OPT: rdata_next[0] = read_sel_reg;
            epwc_pkg::REG_X_WIN: begin
                rdata_next[epwc_pkg::XW-1:0] = win_reg.x_start;
                rdata_next[epwc_pkg::XWIN_END_LSB +: epwc_pkg::XW] = win_reg.x_end;
            end
            epwc_pkg::REG_Y_WIN: begin
                rdata_next[epwc_pkg::YW-1:0] = win_reg.y_start;
                rdata_next[epwc_pkg::YWIN_END_LSB +: epwc_pkg::YW] = win_reg.y_end;
            end
            epwc_pkg::REG_X_PTR: rdata_next[epwc_pkg::XW-1:0] = ptr_reg.x;
            epwc_pkg::REG_Y_PTR: rdata_next[epwc_pkg::YW-1:0] = ptr_reg.y;
            epwc_pkg::REG_ANALOG: rdata_next[7:0] = analog_reg;
            epwc_pkg::REG_DIGITAL: rdata_next[7:0] = digital_reg;
            epwc_pkg::REG_STATUS: begin
                rdata_next[7:0] = cmd_reg;
                rdata_next[epwc_pkg::STS_EXCESS_BIT] = excess_reg;
                rdata_next[epwc_pkg::STS_UNKNOWN_BIT] = unknown_reg;
            end
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !addr_hit(addr8);
            prdata <= (apb_setup && !pwrite) ? rdata_next : 32'h0000_0000;
        end
    end

    // Control and sticky status; a new event beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_en_reg <= epwc_pkg::RST_LINK_EN;
            excess_reg <= 1'b0;
            unknown_reg <= 1'b0;
        end else begin
            if (apb_write && addr8 == epwc_pkg::REG_CTRL) begin
                link_en_reg <= pwdata[epwc_pkg::CTRL_EN_BIT];
            end
            if (excess_take) begin
                excess_reg <= 1'b1;
            end else if (apb_write && addr8 == epwc_pkg::REG_STATUS
                         && pwdata[epwc_pkg::STS_EXCESS_BIT]) begin
                excess_reg <= 1'b0;
            end
            if (cmd_take && param_count(rx_byte.data) == epwc_pkg::NPAR_NONE) begin
                unknown_reg <= 1'b1;
            end else if (apb_write && addr8 == epwc_pkg::REG_STATUS
                         && pwdata[epwc_pkg::STS_UNKNOWN_BIT]) begin
                unknown_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cmd(logic [7:0] c);
        cmd_take && rx_byte.data == c;
    endsequence

    sequence s_par(logic [7:0] c, logic [1:0] i);
        par_take && cmd_reg == c && idx_reg == i;
    endsequence

    a_opt_select: assert property (s_par(epwc_pkg::CMD_READ_OPT, 2'h0)
        |=> ram_read_sel == $past(rx_byte.data[0]))
        else $error("read option bit not taken");

    a_opt_red_hold: assert property (par_take && cmd_reg == epwc_pkg::CMD_READ_OPT
        && rx_byte.data[0] ##1 !par_take[*4] |-> ram_read_sel)
        else $error("red readback select lost");

    a_xwin_pair: assert property (s_par(epwc_pkg::CMD_X_WIN, 2'h0)
        ##[1:1000] s_par(epwc_pkg::CMD_X_WIN, 2'h1)
        |=> win.x_end == $past(rx_byte.data[4:0]) && state_reg == epwc_pkg::EPWC_IDLE)
        else $error("X window end wrong or decoder not idle");

    a_ywin_high: assert property (s_par(epwc_pkg::CMD_Y_WIN, 2'h3)
        |=> win.y_end[8] == $past(rx_byte.data[0])
            && state_reg == epwc_pkg::EPWC_IDLE)
        else $error("Y window end bit 8 wrong");

    a_xptr_load: assert property (s_par(epwc_pkg::CMD_X_PTR, 2'h0)
        |=> ram_address_pointer.x == $past(rx_byte.data[4:0]))
        else $error("X counter preload wrong");

    a_yptr_load: assert property (s_par(epwc_pkg::CMD_Y_PTR, 2'h1)
        |=> ram_address_pointer.y == {$past(rx_byte.data[0]), $past(ptr_reg.y[7:0])})
        else $error("Y counter preload wrong");

    a_cmd_opens: assert property (s_cmd(epwc_pkg::CMD_Y_WIN)
        |=> state_reg == epwc_pkg::EPWC_PARAM && idx_reg == 2'h0)
        else $error("command did not open parameter phase");

    a_excess_drop: assert property (excess_take
        |=> $stable(win) && $stable(ram_address_pointer) && excess_reg)
        else $error("excess byte changed state");

    a_apb_answer: assert property (apb_setup ##1 psel && penable
        |-> pready ##1 !pready)
        else $error("APB answer not one cycle after setup");

endmodule

`default_nettype wire

// >>> shared/epwc_pkg.sv
`default_nettype none

package epwc_pkg;

    // Command codes
    localparam logic [7:0] CMD_READ_OPT = 8'h41;
    localparam logic [7:0] CMD_X_WIN = 8'h44;
    localparam logic [7:0] CMD_Y_WIN = 8'h45;
    localparam logic [7:0] CMD_X_PTR = 8'h4e;
    localparam logic [7:0] CMD_Y_PTR = 8'h4f;
    localparam logic [7:0] CMD_ANALOG = 8'h74;
    localparam logic [7:0] CMD_DIGITAL = 8'h7e;

    // Parameter byte counts per command
    localparam logic [2:0] NPAR_NONE = 3'h0;
    localparam logic [2:0] NPAR_ONE = 3'h1;
    localparam logic [2:0] NPAR_TWO = 3'h2;
    localparam logic [2:0] NPAR_FOUR = 3'h4;

    // Address widths
    localparam int XW = 5;
    localparam int YW = 9;
    localparam int Y_HI = 8;

    // Reset values
    localparam logic RST_READ_SEL = 1'b0;
    localparam logic [XW-1:0] RST_X = 5'h00;
    localparam logic [YW-1:0] RST_Y = 9'h000;
    localparam logic [7:0] RST_BLOCK = 8'h00;
    localparam logic RST_LINK_EN = 1'b1;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RAM_OPT = 8'h04;
    localparam logic [7:0] REG_X_WIN = 8'h08;
    localparam logic [7:0] REG_Y_WIN = 8'h0c;
    localparam logic [7:0] REG_X_PTR = 8'h10;
    localparam logic [7:0] REG_Y_PTR = 8'h14;
    localparam logic [7:0] REG_ANALOG = 8'h18;
    localparam logic [7:0] REG_DIGITAL = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;

    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int XWIN_END_LSB = 8;
    localparam int YWIN_END_LSB = 16;
    localparam int STS_EXCESS_BIT = 8;
    localparam int STS_UNKNOWN_BIT = 9;

    // Link framing
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [0:0] {
        EPWC_IDLE = 1'b0,
        EPWC_PARAM = 1'b1
    } epwc_state_t;

    typedef struct packed {
        logic dc;
        logic [7:0] data;
    } epwc_byte_t;

    typedef struct packed {
        logic [XW-1:0] x_start;
        logic [XW-1:0] x_end;
        logic [YW-1:0] y_start;
        logic [YW-1:0] y_end;
    } epwc_win_t;

    typedef struct packed {
        logic [XW-1:0] x;
        logic [YW-1:0] y;
    } epwc_ptr_t;

endpackage

`default_nettype wire

// >>> tb/epaper_ram_window_commands_tb.sv
`timescale 1ns/1ns
`default_nettype none

module epaper_ram_window_commands_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic spi_sclk, spi_csn, spi_sdi, spi_dc, ram_read_sel;
    logic [7:0] analog_ctrl, digital_ctrl;
    epwc_pkg::epwc_win_t win;
    epwc_pkg::epwc_ptr_t ptr;
    int bad_count;
    int comparisons;

    // Design and far-side host
    epwc_top #(.APB_AW(8)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_sdi(spi_sdi),
        .spi_dc(spi_dc), .ram_read_sel(ram_read_sel), .win(win), .ram_address_pointer(ptr),
        .analog_ctrl(analog_ctrl), .digital_ctrl(digital_ctrl));
    epwc_host_model host_u (.spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_sdi(spi_sdi),
        .spi_dc(spi_dc));

    // Clock at 10 MHz
    always #50 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 10);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 10) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, pready, 1'b1);
            tally_and_finish();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(a, 1'b0, 32'h0000_0000);
        check(rdat, exp);
        check({31'h0, rerr}, {31'h0, err});
    endtask

    // Command frame; parameters taken low byte first from p
    task automatic cmd(input logic [7:0] c, input int n, input logic [31:0] p);
        host_u.start();
        host_u.put(1'b0, c);
        for (int i = 0; i < n; i++) begin
            host_u.put(1'b1, p[8*i+:8]);
        end
        host_u.stop();
        repeat (8) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        bad_count = 0;
        comparisons = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        // Reset values, unmapped place, read-only write ignored
        rd(epwc_pkg::REG_CTRL, 32'h1, 1'b0);
        for (int a = 4; a <= 32; a += 4) rd(a[7:0], 32'h0, 1'b0);
        check({31'h0, ram_read_sel}, 32'h0);
        rd(8'h24, 32'h0, 1'b1);
        apb(epwc_pkg::REG_X_PTR, 1'b1, 32'h1f);
        rd(epwc_pkg::REG_X_PTR, 32'h0, 1'b0);
        // Start-up block controls
        host_u.init_blocks();
        repeat (8) @(posedge pclk);
        check({24'h0, analog_ctrl}, 32'h54);
        check({24'h0, digital_ctrl}, 32'h3b);
        rd(epwc_pkg::REG_DIGITAL, 32'h3b, 1'b0);
        // Readback source, upper option bits ignored
        cmd(epwc_pkg::CMD_READ_OPT, 1, 32'h01);
        check({31'h0, ram_read_sel}, 32'h1);
        rd(epwc_pkg::REG_RAM_OPT, 32'h1, 1'b0);
        cmd(epwc_pkg::CMD_READ_OPT, 1, 32'hfe);
        check({31'h0, ram_read_sel}, 32'h0);
        // Window positions
        cmd(epwc_pkg::CMD_X_WIN, 2, 32'h3100);
        check({27'h0, win.x_start}, 32'h0);
        check({27'h0, win.x_end}, 32'h11);
        rd(epwc_pkg::REG_X_WIN, 32'h1100, 1'b0);
        cmd(epwc_pkg::CMD_Y_WIN, 4, 32'h0000_012b);
        rd(epwc_pkg::REG_Y_WIN, 32'h0000_012b, 1'b0);
        cmd(epwc_pkg::CMD_Y_WIN, 4, 32'h0134_01ff);
        check({23'h0, win.y_start}, 32'h1ff);
        check({23'h0, win.y_end}, 32'h134);
        // Address counter preloads
        cmd(epwc_pkg::CMD_X_PTR, 1, 32'h1f);
        check({27'h0, ptr.x}, 32'h1f);
        cmd(epwc_pkg::CMD_X_PTR, 1, 32'h00);
        rd(epwc_pkg::REG_X_PTR, 32'h0, 1'b0);
        cmd(epwc_pkg::CMD_Y_PTR, 2, 32'h012b);
        check({23'h0, ptr.y}, 32'h12b);
        rd(epwc_pkg::REG_Y_PTR, 32'h12b, 1'b0);
        // Excess byte ignored and flagged, then cleared
        cmd(epwc_pkg::CMD_X_PTR, 2, 32'h0705);
        check({27'h0, ptr.x}, 32'h05);
        rd(epwc_pkg::REG_STATUS, 32'h14e, 1'b0);
        apb(epwc_pkg::REG_STATUS, 1'b1, 32'h100);
        rd(epwc_pkg::REG_STATUS, 32'h04e, 1'b0);
        // Unknown code opens no parameters
        cmd(8'h30, 1, 32'h09);
        rd(epwc_pkg::REG_STATUS, 32'h330, 1'b0);
        // New command aborts a half-sent window
        cmd(epwc_pkg::CMD_Y_WIN, 1, 32'h77);
        cmd(epwc_pkg::CMD_X_PTR, 1, 32'h03);
        check({23'h0, win.y_start}, 32'h177);
        check({27'h0, ptr.x}, 32'h03);
        // Link disabled drops bytes
        apb(epwc_pkg::REG_CTRL, 1'b1, 32'h0);
        cmd(epwc_pkg::CMD_X_PTR, 1, 32'h0a);
        check({27'h0, ptr.x}, 32'h03);
        apb(epwc_pkg::REG_CTRL, 1'b1, 32'h1);
        repeat (3) @(posedge pclk);
        cmd(epwc_pkg::CMD_X_PTR, 1, 32'h0a);
        check({27'h0, ptr.x}, 32'h0a);
        tally_and_finish();
    end
endmodule

`default_nettype wire

// >>> tb/epwc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module epwc_host_model (
    // Serial link driven into the device
    output logic spi_sclk,
    output logic spi_csn,
    output logic spi_sdi,
    output logic spi_dc
);
    localparam int HALF_NS = 400;
    localparam int SKEW_NS = 25;

    // Idle lines: clock parked low, device deselected
    initial begin
        spi_sclk = 1'b0;
        spi_csn = 1'b1;
        spi_sdi = 1'b0;
        spi_dc = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Select the device, leaving setup time before the first rise
    task automatic start();
        #SKEW_NS; // Keeps every pin change off the device's clock edge
        spi_csn = 1'b0;
        #HALF_NS;
    endtask

    // One byte MSB first; select level held over the whole byte
    task automatic put(input logic dc, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            spi_dc = dc;
            spi_sdi = b[i];
            #HALF_NS spi_sclk = 1'b1;
            #HALF_NS spi_sclk = 1'b0;
        end
    endtask

    // Deselected lines must not keep the last value, so flip them
    task automatic stop();
        #HALF_NS spi_csn = 1'b1;
        spi_sdi = ~spi_sdi;
        spi_dc = ~spi_dc;
        #HALF_NS;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Block control values sent at start-up
    task automatic init_blocks();
        start();
        put(1'b0, epwc_pkg::CMD_ANALOG);
        put(1'b1, 8'h54);
        put(1'b0, epwc_pkg::CMD_DIGITAL);
        put(1'b1, 8'h3b);
        stop();
    endtask
endmodule

`default_nettype wire
